// file: rtl/flash_ctrl_defines.svh
// Offsets, field positions, reset values and codes of the flash rewrite control
`ifndef FLASH_CTRL_DEFINES_SVH
`define FLASH_CTRL_DEFINES_SVH
// Register indices
`define REG_CTRL0 4'h0
`define REG_CTRL1 4'h1
`define REG_CTRL4 4'h2
`define REG_CMD 4'h3
`define REG_PDATA 4'h4
`define REG_EXEC_BLK 4'h5
`define REG_STATUS 4'h6
`define REG_OPTION 4'h7
// Control register 0 fields
`define C0_READY 0
`define C0_CPU_REWR 1
`define C0_LOW_MASTER 2
`define C0_PROG_ERR 6
`define C0_ERASE_ERR 7
// Control register 1 fields
`define C1_EXEC_SEL 1
`define C1_BLK0_LOCK 5
`define C1_BLK1_LOCK 6
// Control register 4 fields
`define C4_SUSP_EN 0
`define C4_ERASE_SREQ 1
`define C4_PROG_SREQ 2
`define C4_ERASE_RUN 3
`define C4_PROG_RUN 4
`define C4_READ_EN 6
// Status register fields
`define SR_READY 7
`define SR_ERASE_ERR 5
`define SR_PROG_ERR 4
// Option byte fields
`define OPT_PROT_ONE 2
`define OPT_PROT_REL 3
`define OPT_ERASED 8'hff
`define OPT_BLOCK 2'h0
// Reset values
`define CTRL0_RST 8'h01
`define CTRL1_RST 8'h60
`define CTRL4_RST 8'h40
// Command codes
`define CMD_READ_ARRAY 3'h1
`define CMD_READ_STATUS 3'h2
`define CMD_CLEAR_STATUS 3'h3
`define CMD_PROGRAM 3'h4
`define CMD_ERASE 3'h5
// Stored identification byte addresses
`define ID_COUNT 3'h7
`define ID_ADDR0 24'h00ffdf
`define ID_ADDR1 24'h00ffe3
`define ID_ADDR2 24'h00ffeb
`define ID_ADDR3 24'h00ffef
`define ID_ADDR4 24'h00fff3
`define ID_ADDR5 24'h00fff7
`define ID_ADDR6 24'h00fffb
`endif

// file: rtl/flash_ctrl_pkg.sv
// Types shared by the flash rewrite control
package flash_ctrl_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_SUSP_WAIT, ST_SUSP} op_state_t;
  typedef struct packed {
    logic [2:0] code;
    logic [1:0] block;
  } cmd_t;
  typedef struct packed {
    logic prog;
    logic erase;
    logic [1:0] block;
    logic [7:0] data;
  } array_req_t;
endpackage

// file: rtl/flash_rewrite_protect_ctrl.sv
// Flash rewrite enable gating, suspend sequencing, ID check and code protect
`timescale 1ns/1ps
`include "flash_ctrl_defines.svh"

// Overview of operation
// - Low blocks 0 and 1 refuse program/erase unless master enable is 1.
// - With master set, each low block accepts rewrite only when its lock is 0.
// - Boot area shares user addresses but is a separate array.
// - Serial boot on non-blank flash ignores programmer commands on ID mismatch.
// - Seven stored ID bytes sit at fixed addresses 00FFDFh through 00FFFBh.
// - Protect bit one 0 and release bit 1 block parallel read and rewrite.
// - Erasing the option byte block leaves the option byte at FFh.
// - Interrupt during erase pauses erase; user ROM readable meanwhile.
// - Interrupt during programming pauses it; user ROM readable meanwhile.
// - Flash-executed mode refuses running block and read-status command.
// - After operation: RAM mode in read-status, flash mode in read-array.
// - CPU runs in RAM mode; held in flash mode during operations.
// - Ready and error flags readable; RAM mode also via status bits 7,5,4.
// - Flash mode suspends automatically on enabled interrupt with enable set.
// - Rewrite enable accepts commands; select bit 0 RAM mode, 1 flash mode.
// - Ready flag is 0 during operation and suspend, else 1.
// - Read enable status is 0 while running and while settling into suspend, 1 once suspended or idle.
module flash_rewrite_protect_ctrl
  import flash_ctrl_pkg::*;
#(
  parameter int PROG_CYCLES = 16,
  parameter int ERASE_CYCLES = 64,
  parameter int SUSP_CYCLES = 4
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic irq_req_in,
  input wire logic array_fail_in,
  input wire logic [7:0] option_byte_in,
  input wire logic flash_blank_in,
  input wire logic serial_boot_in,
  input wire logic parallel_mode_in,
  input wire logic [7:0] id_byte_in,
  input wire logic id_valid_in,
  input wire logic [7:0] stored_id_in,
  input wire logic prog_cmd_valid_in,
  output logic [23:0] id_addr_out,
  output logic id_ok_out,
  output logic prog_cmd_accept_out,
  output logic boot_array_sel_out,
  output logic parallel_block_out,
  output array_req_t array_req_out,
  output logic cpu_hold_out,
  output logic status_mode_out
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [23:0] id_addr(input logic [2:0] idx);
    case (idx)
      3'h0: id_addr = `ID_ADDR0;
      3'h1: id_addr = `ID_ADDR1;
      3'h2: id_addr = `ID_ADDR2;
      3'h3: id_addr = `ID_ADDR3;
      3'h4: id_addr = `ID_ADDR4;
      3'h5: id_addr = `ID_ADDR5;
      default: id_addr = `ID_ADDR6;
    endcase
  endfunction

  function automatic logic [15:0] cnt_of(input int cycles);
    cnt_of = 16'(cycles - 1);
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic cpu_rewr, low_master, prog_err, erase_err;
  logic exec_sel, blk0_lock, blk1_lock;
  logic susp_en, erase_sreq, prog_sreq;
  logic [7:0] pdata;
  logic [1:0] exec_blk;
  logic [7:0] option_byte;
  logic opt_loaded;
  op_state_t state;
  logic op_erase;
  logic [1:0] op_block;
  logic [15:0] cnt;
  logic [2:0] boot_sync, par_sync;
  logic boot_mode, par_mode;
  logic [2:0] id_idx;
  logic id_miss;
  // Reset images as vectors so single fields can be picked
  localparam logic [7:0] CTRL0_RST_V = `CTRL0_RST;
  localparam logic [7:0] CTRL1_RST_V = `CTRL1_RST;
  localparam logic [7:0] CTRL4_RST_V = `CTRL4_RST;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  cmd_t cmd;
  assign cmd = '{code: wdata_in[2:0], block: wdata_in[5:4]};
  wire cmd_wr = wr_in && addr_in == `REG_CMD && cpu_rewr;
  wire busy = state != ST_IDLE;
  wire is_op = cmd.code == `CMD_PROGRAM || cmd.code == `CMD_ERASE;
  wire low_blk = cmd.block == 2'h0 || cmd.block == 2'h1;
  wire lock_hit = cmd.block == 2'h0 ? blk0_lock : blk1_lock;
  wire low_refuse = low_blk && (!low_master || lock_hit);
  wire exec_refuse = exec_sel && cmd.block == exec_blk;
  wire op_start = cmd_wr && is_op && !busy && !low_refuse && !exec_refuse;
  wire op_refused = cmd_wr && is_op && !busy && (low_refuse || exec_refuse);
  wire run_done = state == ST_RUN && cnt == 16'h0;
  // Flash mode: enabled interrupt raises the request bit itself
  wire auto_susp = exec_sel && susp_en && irq_req_in && state == ST_RUN;
  wire sreq = op_erase ? erase_sreq : prog_sreq;
  wire susp_go = state == ST_RUN && (sreq || auto_susp) && susp_en;
  wire ready = !busy;
  wire read_en = state != ST_RUN && state != ST_SUSP_WAIT;
  wire opt_erased = run_done && op_erase && op_block == `OPT_BLOCK;
  wire ctrl4_wr = wr_in && addr_in == `REG_CTRL4;
  wire id_step = boot_mode && id_valid_in && id_idx != `ID_COUNT;

  logic [7:0] ctrl0_v, ctrl1_v, ctrl4_v, status_v, next_rdata;
  always_comb begin
    ctrl0_v = 8'h00;
    ctrl0_v[`C0_READY] = ready;
    ctrl0_v[`C0_CPU_REWR] = cpu_rewr;
    ctrl0_v[`C0_LOW_MASTER] = low_master;
    ctrl0_v[`C0_PROG_ERR] = prog_err;
    ctrl0_v[`C0_ERASE_ERR] = erase_err;
    ctrl1_v = 8'h00;
    ctrl1_v[`C1_EXEC_SEL] = exec_sel;
    ctrl1_v[`C1_BLK0_LOCK] = blk0_lock;
    ctrl1_v[`C1_BLK1_LOCK] = blk1_lock;
    ctrl4_v = 8'h00;
    ctrl4_v[`C4_SUSP_EN] = susp_en;
    ctrl4_v[`C4_ERASE_SREQ] = erase_sreq;
    ctrl4_v[`C4_PROG_SREQ] = prog_sreq;
    ctrl4_v[`C4_ERASE_RUN] = busy && op_erase;
    ctrl4_v[`C4_PROG_RUN] = busy && !op_erase;
    ctrl4_v[`C4_READ_EN] = read_en;
    status_v = 8'h00;
    status_v[`SR_READY] = ready;
    status_v[`SR_ERASE_ERR] = erase_err;
    status_v[`SR_PROG_ERR] = prog_err;
  end

  always_comb begin
    case (addr_in)
      `REG_CTRL0: next_rdata = ctrl0_v;
      `REG_CTRL1: next_rdata = ctrl1_v;
      `REG_CTRL4: next_rdata = ctrl4_v;
      `REG_PDATA: next_rdata = pdata;
      `REG_EXEC_BLK: next_rdata = {6'h00, exec_blk};
      // Flash-executed mode has no status read path
      `REG_STATUS: next_rdata = (status_mode_out && !exec_sel) ? status_v : 8'h00;
      `REG_OPTION: next_rdata = option_byte;
      default: next_rdata = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {cpu_rewr, low_master} <= {CTRL0_RST_V[`C0_CPU_REWR], CTRL0_RST_V[`C0_LOW_MASTER]};
      {exec_sel, blk0_lock, blk1_lock} <= {CTRL1_RST_V[`C1_EXEC_SEL],
        CTRL1_RST_V[`C1_BLK0_LOCK], CTRL1_RST_V[`C1_BLK1_LOCK]};
      pdata <= 8'h00;
      exec_blk <= 2'h0;
    end else if (wr_in) begin
      case (addr_in)
        `REG_CTRL0: begin
          cpu_rewr <= wdata_in[`C0_CPU_REWR];
          low_master <= wdata_in[`C0_LOW_MASTER];
        end
        // Mode select can only be set while rewrite is enabled; a write with rewrite disabled clears it
        `REG_CTRL1: begin
          exec_sel <= cpu_rewr & wdata_in[`C1_EXEC_SEL];
          blk0_lock <= wdata_in[`C1_BLK0_LOCK];
          blk1_lock <= wdata_in[`C1_BLK1_LOCK];
        end
        `REG_PDATA: pdata <= wdata_in;
        `REG_EXEC_BLK: exec_blk <= wdata_in[1:0];
        default: ;
      endcase
    end
  end

  // Suspend controls; hardware set wins over a software clear
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {susp_en, erase_sreq, prog_sreq} <= {CTRL4_RST_V[`C4_SUSP_EN],
        CTRL4_RST_V[`C4_ERASE_SREQ], CTRL4_RST_V[`C4_PROG_SREQ]};
    end else begin
      if (ctrl4_wr) begin
        susp_en <= wdata_in[`C4_SUSP_EN];
        erase_sreq <= wdata_in[`C4_ERASE_SREQ];
        prog_sreq <= wdata_in[`C4_PROG_SREQ];
      end
      if (auto_susp && op_erase) begin
        erase_sreq <= 1'b1;
      end
      if (auto_susp && !op_erase) begin
        prog_sreq <= 1'b1;
      end
      if (run_done) begin
        erase_sreq <= 1'b0;
        prog_sreq <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Operation sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= ST_IDLE;
      op_erase <= 1'b0;
      op_block <= 2'h0;
      cnt <= 16'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (op_start) begin
            state <= ST_RUN;
            op_erase <= cmd.code == `CMD_ERASE;
            op_block <= cmd.block;
            cnt <= cnt_of(cmd.code == `CMD_ERASE ? ERASE_CYCLES : PROG_CYCLES);
          end
        end
        ST_RUN: begin
          if (run_done) begin
            state <= ST_IDLE;
          end else if (susp_go) begin
            state <= ST_SUSP_WAIT;
            cnt <= cnt_of(SUSP_CYCLES);
          end else begin
            cnt <= cnt - 16'h1;
          end
        end
        // Array needs a settling time before reads are safe; resume restarts the count
        ST_SUSP_WAIT: begin
          if (cnt == 16'h0) begin
            state <= ST_SUSP;
          end else begin
            cnt <= cnt - 16'h1;
          end
        end
        ST_SUSP: begin
          if (!sreq) begin
            state <= ST_RUN;
            cnt <= cnt_of(op_erase ? ERASE_CYCLES : PROG_CYCLES);
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Error flags and read mode
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prog_err <= CTRL0_RST_V[`C0_PROG_ERR];
      erase_err <= CTRL0_RST_V[`C0_ERASE_ERR];
      status_mode_out <= 1'b0;
    end else begin
      if (cmd_wr && cmd.code == `CMD_CLEAR_STATUS) begin
        prog_err <= 1'b0;
        erase_err <= 1'b0;
      end
      if ((run_done && array_fail_in && !op_erase) ||
          (op_refused && cmd.code == `CMD_PROGRAM)) begin
        prog_err <= 1'b1;
      end
      if ((run_done && array_fail_in && op_erase) ||
          (op_refused && cmd.code == `CMD_ERASE)) begin
        erase_err <= 1'b1;
      end
      if (cmd_wr && cmd.code == `CMD_READ_ARRAY) begin
        status_mode_out <= 1'b0;
      end else if (cmd_wr && cmd.code == `CMD_READ_STATUS && !exec_sel) begin
        status_mode_out <= 1'b1;
      end else if (run_done) begin
        status_mode_out <= !exec_sel;
      end
    end
  end

  // ------------------------------------------------------------
  // Array drive and CPU hold
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      array_req_out <= '0;
      cpu_hold_out <= 1'b0;
    end else begin
      // Paused operation releases the array so user ROM reads work
      array_req_out.prog <= (op_start && cmd.code == `CMD_PROGRAM) ||
        (state == ST_RUN && !op_erase && !run_done && !susp_go);
      array_req_out.erase <= (op_start && cmd.code == `CMD_ERASE) ||
        (state == ST_RUN && op_erase && !run_done && !susp_go);
      array_req_out.block <= op_start ? cmd.block : op_block;
      array_req_out.data <= pdata;
      // RAM mode keeps the CPU running; ports hold outside this block
      cpu_hold_out <= exec_sel && ((op_start) ||
        (state == ST_RUN && !run_done && !susp_go));
    end
  end

  // ------------------------------------------------------------
  // Option byte and parallel protect
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      option_byte <= `OPT_ERASED;
      opt_loaded <= 1'b0;
      parallel_block_out <= 1'b0;
    end else begin
      if (!opt_loaded) begin
        option_byte <= option_byte_in;
        opt_loaded <= 1'b1;
      end else if (opt_erased) begin
        option_byte <= `OPT_ERASED;
      end
      parallel_block_out <= par_mode && !option_byte[`OPT_PROT_ONE] &&
        option_byte[`OPT_PROT_REL];
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      boot_sync <= 3'h0;
      par_sync <= 3'h0;
      boot_mode <= 1'b0;
      par_mode <= 1'b0;
      boot_array_sel_out <= 1'b0;
    end else begin
      boot_sync <= {boot_sync[1:0], serial_boot_in};
      par_sync <= {par_sync[1:0], parallel_mode_in};
      if (boot_sync[1] == boot_sync[2]) begin
        boot_mode <= boot_sync[2];
      end
      if (par_sync[1] == par_sync[2]) begin
        par_mode <= par_sync[2];
      end
      // Same addresses, other array while boot mode holds
      boot_array_sel_out <= boot_mode;
    end
  end

  // ------------------------------------------------------------
  // Serial boot identity check
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      id_idx <= 3'h0;
      id_miss <= 1'b0;
      id_addr_out <= `ID_ADDR0;
      id_ok_out <= 1'b0;
      prog_cmd_accept_out <= 1'b0;
    end else begin
      if (!boot_mode) begin
        id_idx <= 3'h0;
        id_miss <= 1'b0;
        id_addr_out <= `ID_ADDR0;
      end else if (id_step) begin
        id_idx <= id_idx + 3'h1;
        id_addr_out <= id_addr(id_idx + 3'h1);
        if (id_byte_in != stored_id_in) begin
          id_miss <= 1'b1;
        end
      end
      // Blank flash skips the comparison
      id_ok_out <= boot_mode && (flash_blank_in ||
        (id_idx == `ID_COUNT && !id_miss));
      prog_cmd_accept_out <= prog_cmd_valid_in && id_ok_out;
    end
  end

endmodule // flash_rewrite_protect_ctrl

// file: tb/flash_array_model.sv
// Behavioural flash array and stored ID byte source
`timescale 1ns/1ps
module flash_array_model
  import flash_ctrl_pkg::*;
(
  input wire logic clk_in,
  input wire logic [23:0] id_addr_in,
  input wire array_req_t req_in,
  input wire logic fail_in,
  output logic [7:0] stored_id_out,
  output logic array_fail_out
);
  logic spin = 1'b0;
  always_ff @(posedge clk_in) begin
    spin <= ~spin;
  end
  // Software has placed one byte per fixed ID address
  assign stored_id_out = id_addr_in[7:0] ^ 8'ha5;
  // Fail line is meaningless while idle, so it never holds a stale value
  assign array_fail_out = (req_in.prog | req_in.erase) ? fail_in : spin;
endmodule // flash_array_model

// file: tb/flash_rewrite_protect_ctrl_chk.sv
// Port-level assertions for the flash rewrite control
`timescale 1ns/1ps
`include "flash_ctrl_defines.svh"
module flash_rewrite_protect_ctrl_chk
  import flash_ctrl_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic irq_req_in,
  input wire logic array_fail_in,
  input wire logic [7:0] option_byte_in,
  input wire logic flash_blank_in,
  input wire logic serial_boot_in,
  input wire logic parallel_mode_in,
  input wire logic [7:0] id_byte_in,
  input wire logic id_valid_in,
  input wire logic [7:0] stored_id_in,
  input wire logic prog_cmd_valid_in,
  input wire logic [23:0] id_addr_out,
  input wire logic id_ok_out,
  input wire logic prog_cmd_accept_out,
  input wire logic boot_array_sel_out,
  input wire logic parallel_block_out,
  input wire array_req_t array_req_out,
  input wire logic cpu_hold_out,
  input wire logic status_mode_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic busy;
  assign busy = array_req_out.prog | array_req_out.erase;
  sequence s_read_busy(logic [3:0] idx);
    busy && rd_in && addr_in == idx;
  endsequence
  sequence s_par_idle;
    (!parallel_mode_in) [*7];
  endsequence
  AST_ACCEPT: assert property (prog_cmd_accept_out |-> $past(prog_cmd_valid_in) && $past(id_ok_out))
    else $error("accept without valid command and ok");
  AST_ACCEPT_GO: assert property (prog_cmd_valid_in && id_ok_out |=> prog_cmd_accept_out)
    else $error("command dropped while ok");
  AST_PAR_IDLE: assert property (s_par_idle |-> !parallel_block_out)
    else $error("parallel block outside parallel mode");
  AST_ID_ADDR: assert property (id_addr_out inside {`ID_ADDR0, `ID_ADDR1, `ID_ADDR2,
    `ID_ADDR3, `ID_ADDR4, `ID_ADDR5, `ID_ADDR6}) else $error("id address off table");
  AST_ID_RISE: assert property ($rose(id_ok_out) |-> $past(id_valid_in) ||
    $past(id_valid_in, 2) || $past(flash_blank_in)) else $error("id ok without bytes");
  AST_STATUS_ZERO: assert property (rd_in && addr_in == `REG_STATUS && !status_mode_out
    |=> rdata_out == 8'h00) else $error("status readable outside status mode");
  AST_RDY_RUN: assert property (s_read_busy(`REG_CTRL0) |=> !rdata_out[`C0_READY])
    else $error("ready high while array works");
  AST_RDEN_RUN: assert property (s_read_busy(`REG_CTRL4) |=> !rdata_out[`C4_READ_EN])
    else $error("read enable high while array works");
endmodule // flash_rewrite_protect_ctrl_chk

bind flash_rewrite_protect_ctrl flash_rewrite_protect_ctrl_chk chk (.clk_in(clk_in),
  .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .irq_req_in(irq_req_in), .array_fail_in(array_fail_in),
  .option_byte_in(option_byte_in), .flash_blank_in(flash_blank_in),
  .serial_boot_in(serial_boot_in), .parallel_mode_in(parallel_mode_in),
  .id_byte_in(id_byte_in), .id_valid_in(id_valid_in), .stored_id_in(stored_id_in),
  .prog_cmd_valid_in(prog_cmd_valid_in), .id_addr_out(id_addr_out), .id_ok_out(id_ok_out),
  .prog_cmd_accept_out(prog_cmd_accept_out), .boot_array_sel_out(boot_array_sel_out),
  .parallel_block_out(parallel_block_out), .array_req_out(array_req_out),
  .cpu_hold_out(cpu_hold_out), .status_mode_out(status_mode_out));

// file: tb/test_flash_rewrite_protect_ctrl.sv
// Self-checking bench for the flash rewrite control
`timescale 1ns/1ps
`include "flash_ctrl_defines.svh"
module test_flash_rewrite_protect_ctrl;
  import flash_ctrl_pkg::*;
  logic clk_in, arst_n_in, wr_in, rd_in, irq_req_in, fail, flash_blank_in, serial_boot_in;
  logic parallel_mode_in, id_valid_in, prog_cmd_valid_in, array_fail_in, id_ok_out;
  logic prog_cmd_accept_out, boot_array_sel_out, parallel_block_out, cpu_hold_out;
  logic status_mode_out;
  logic [3:0] addr_in;
  logic [7:0] wdata_in, rdata_out, option_byte_in, id_byte_in, stored_id_in, d;
  logic [23:0] id_addr_out;
  array_req_t array_req_out;
  logic [23:0] ids [7] = '{`ID_ADDR0, `ID_ADDR1, `ID_ADDR2, `ID_ADDR3, `ID_ADDR4,
    `ID_ADDR5, `ID_ADDR6};
  int failures = 0;
  int total_checks = 0;
  flash_rewrite_protect_ctrl #(.PROG_CYCLES(8), .ERASE_CYCLES(16), .SUSP_CYCLES(2)) uut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_req_in(irq_req_in),
    .array_fail_in(array_fail_in), .option_byte_in(option_byte_in),
    .flash_blank_in(flash_blank_in), .serial_boot_in(serial_boot_in),
    .parallel_mode_in(parallel_mode_in), .id_byte_in(id_byte_in), .id_valid_in(id_valid_in),
    .stored_id_in(stored_id_in), .prog_cmd_valid_in(prog_cmd_valid_in),
    .id_addr_out(id_addr_out), .id_ok_out(id_ok_out), .prog_cmd_accept_out(prog_cmd_accept_out),
    .boot_array_sel_out(boot_array_sel_out), .parallel_block_out(parallel_block_out),
    .array_req_out(array_req_out), .cpu_hold_out(cpu_hold_out),
    .status_mode_out(status_mode_out));
  flash_array_model model (.clk_in(clk_in), .id_addr_in(id_addr_out), .req_in(array_req_out),
    .fail_in(fail), .stored_id_out(stored_id_in), .array_fail_out(array_fail_in));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic cmd(input logic [2:0] c, input logic [1:0] b);
    wr(`REG_CMD, {2'h0, b, 1'b0, c});
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      rd(`REG_CTRL0);
      n++;
    end while (d[`C0_READY] !== 1'b1 && n < 100);
    chk1(d[`C0_READY], 1'b1);
  endtask
  task automatic t_reset;
    logic [3:0] idx [5] = '{`REG_CTRL0, `REG_CTRL1, `REG_CTRL4, `REG_OPTION, 4'hf};
    logic [7:0] exp [5] = '{`CTRL0_RST, `CTRL1_RST, `CTRL4_RST, 8'h08, 8'h00};
    wr(4'hf, 8'hff);
    for (int i = 0; i < 5; i++) begin
      rd(idx[i]);
      chk8(d, exp[i]);
    end
    parallel_mode_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk1(parallel_block_out, 1'b1);
  endtask
  task automatic t_gating;
    wr(`REG_CTRL0, 8'h02);
    cmd(`CMD_ERASE, 2'h0);
    chk1(array_req_out.erase, 1'b0);
    rd(`REG_CTRL0);
    chk1(d[`C0_ERASE_ERR], 1'b1);
    wr(`REG_CTRL0, 8'h06);
    wr(`REG_CTRL1, 8'h40);
    cmd(`CMD_PROGRAM, 2'h1);
    chk1(array_req_out.prog, 1'b0);
    rd(`REG_CTRL0);
    chk1(d[`C0_PROG_ERR], 1'b1);
    cmd(`CMD_CLEAR_STATUS, 2'h0);
    cmd(`CMD_ERASE, 2'h0);
    chk1(array_req_out.erase, 1'b1);
    rd(`REG_CTRL4);
    chk1(d[`C4_ERASE_RUN], 1'b1);
    wait_done;
    chk1(status_mode_out, 1'b1);
    rd(`REG_STATUS);
    chk8(d, 8'h80);
    rd(`REG_OPTION);
    chk8(d, `OPT_ERASED);
    repeat (8) @(posedge clk_in);
    chk1(parallel_block_out, 1'b0);
  endtask
  task automatic t_suspend(input logic erase);
    // Bench plays the RAM-mode CPU; its clock limit is the system's concern
    wr(`REG_CTRL4, 8'h01);
    fail <= ~erase;
    wr(`REG_PDATA, 8'h3c);
    cmd(erase ? `CMD_ERASE : `CMD_PROGRAM, 2'h3);
    if (!erase) chk8(array_req_out.data, 8'h3c);
    chk8({6'h00, array_req_out.block}, 8'h03);
    chk1(cpu_hold_out, 1'b0);
    wr(`REG_CTRL4, erase ? 8'h03 : 8'h05);
    repeat (5) @(posedge clk_in);
    chk1(array_req_out.erase | array_req_out.prog, 1'b0);
    rd(`REG_CTRL4);
    chk1(d[`C4_READ_EN], 1'b1);
    rd(`REG_CTRL0);
    chk1(d[`C0_READY], 1'b0);
    wr(`REG_CTRL4, 8'h01);
    repeat (2) @(posedge clk_in);
    #1 chk1(array_req_out.erase | array_req_out.prog, 1'b1);
    wait_done;
    chk1(d[`C0_PROG_ERR], ~erase);
    cmd(`CMD_READ_STATUS, 2'h0);
    rd(`REG_STATUS);
    chk8(d, erase ? 8'h80 : 8'h90);
    fail <= 1'b0;
    cmd(`CMD_CLEAR_STATUS, 2'h0);
    cmd(`CMD_READ_ARRAY, 2'h0);
    chk1(status_mode_out, 1'b0);
  endtask
  task automatic t_flash_mode;
    wr(`REG_CTRL1, 8'h02);
    wr(`REG_EXEC_BLK, 8'h02);
    cmd(`CMD_ERASE, 2'h2);
    chk1(array_req_out.erase, 1'b0);
    cmd(`CMD_CLEAR_STATUS, 2'h0);
    cmd(`CMD_ERASE, 2'h3);
    chk1(cpu_hold_out, 1'b1);
    irq_req_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    chk1(array_req_out.erase, 1'b0);
    irq_req_in <= 1'b0;
    rd(`REG_CTRL4);
    chk1(d[`C4_ERASE_SREQ], 1'b1);
    wr(`REG_CTRL4, 8'h01);
    wait_done;
    chk1(status_mode_out, 1'b0);
    chk1(cpu_hold_out, 1'b0);
    cmd(`CMD_READ_STATUS, 2'h0);
    rd(`REG_STATUS);
    chk8(d, 8'h00);
  endtask
  task automatic send_id(input int bad);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_in);
      chk8(id_addr_out[7:0], ids[i][7:0]);
      id_byte_in <= (ids[i][7:0] ^ 8'ha5) ^ ((i == bad) ? 8'h01 : 8'h00);
      id_valid_in <= 1'b1;
      @(posedge clk_in);
      id_valid_in <= 1'b0;
    end
    repeat (3) @(posedge clk_in);
    prog_cmd_valid_in <= 1'b1;
    @(posedge clk_in);
    prog_cmd_valid_in <= 1'b0;
    #1 chk1(prog_cmd_accept_out, bad == 7);
    chk1(id_ok_out, bad == 7);
  endtask
  task automatic t_serial;
    serial_boot_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk1(id_ok_out, 1'b0);
    chk1(boot_array_sel_out, 1'b1);
    send_id(7);
    serial_boot_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    serial_boot_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    send_id(6);
    flash_blank_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk1(id_ok_out, 1'b1);
  endtask
  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    results();
  end
  initial begin
    {arst_n_in, wr_in, rd_in, irq_req_in, fail, flash_blank_in} = '0;
    {serial_boot_in, parallel_mode_in, id_valid_in, prog_cmd_valid_in} = '0;
    {addr_in, wdata_in, id_byte_in} = '0;
    option_byte_in = 8'h08;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    t_reset();
    t_gating();
    t_suspend(1'b1);
    t_suspend(1'b0);
    t_flash_mode();
    t_serial();
    results();
  end
endmodule // test_flash_rewrite_protect_ctrl
